/* fsor_regs.svh */
// Register map and timing constants of the floppy status/output registers.
// Assumes a 20 MHz bus clock; included by bare name.
`ifndef FSOR_REGS_SVH
`define FSOR_REGS_SVH

`define FSOR_IDX_SRA 4'h0
`define FSOR_IDX_SRB 4'h1
`define FSOR_IDX_DOR 4'h2
`define FSOR_IDX_CFG 4'h3
`define FSOR_BYTE_ADDR(idx) ({idx, 2'b00})

`define FSOR_DOR_SEL_LSB 0
`define FSOR_DOR_RST_BIT 2
`define FSOR_DOR_DMA_BIT 3
`define FSOR_DOR_MOT_LSB 4
`define FSOR_DOR_RESET 8'h00

`define FSOR_CFG_MFM_BIT 0
`define FSOR_CFG_IDENT_BIT 1
`define FSOR_CFG_FWP_EN_BIT 2
`define FSOR_CFG_FWP_VAL_BIT 3
`define FSOR_CFG_RESET 8'h03

`define FSOR_CLK_MHZ 20
`define FSOR_SRST_NS 100
`define FSOR_SRST_CYC ((`FSOR_SRST_NS * `FSOR_CLK_MHZ + 999) / 1000)

`endif

/* fsor_pkg.sv */
// Types shared by the floppy status/output register block.
// Assumes nothing of its surroundings.
package fsor_pkg;

    typedef enum logic [1:0] {
        fsor_basic = 2'b00,
        fsor_enhanced = 2'b01,
        fsor_compact = 2'b10
    } fsor_mode_t;

endpackage

/* fsor_top.sv */
// Floppy controller status A/B, output register and config, AHB-Lite slave.
// Assumes synchronous drive-side inputs and a single-slave AHB-Lite bus.
`timescale 1ns/100ps
`include "fsor_regs.svh"

module fsor_top #(
    parameter int SRST_CYC = `FSOR_SRST_CYC
) (
    input wire logic hclk, // Bus clock
    input wire logic hresetn, // Async reset, active low
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write access
    input wire logic [2:0] hsize, // Transfer size
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready in
    output logic hreadyout, // Slave ready
    output logic hresp, // Response, always OKAY
    output logic [31:0] hrdata, // Read data
    output logic data_float, // Status read left lines floating
    input wire logic dir_read_pulse, // Input register read strobe
    input wire logic step_out, // Head step output level
    input wire logic head_dir_in, // Head direction, 1 inward
    input wire logic write_protect, // Disk write protect
    input wire logic index_in, // Index pulse
    input wire logic head_side, // Head select, 1 side 1
    input wire logic track_zero, // Track zero
    input wire logic write_gate, // Write gate output level
    input wire logic read_data, // Read data, active high
    input wire logic write_data, // Write data, active high
    input wire logic core_irq, // Interrupt from core
    input wire logic core_drq, // DMA request from core
    input wire logic dack_in_n, // DMA acknowledge pin
    input wire logic tc_in, // Terminal count pin
    output logic dack_core_n, // Gated acknowledge to core
    output logic tc_core, // Gated terminal count to core
    output logic floppy_irq_out, // Interrupt pin level
    output logic floppy_irq_oe_n, // Interrupt pin enable, low drives
    output logic dma_req_out, // DMA request pin level
    output logic dma_req_oe_n, // DMA request enable, low drives
    output logic drive_sel_out_0, // Drive select 0
    output logic drive_sel_out_1, // Drive select 1
    output logic drive_sel_out_2, // Drive select 2
    output logic drive_sel_out_3, // Drive select 3
    output logic motor_out_0, // Motor 0
    output logic motor_out_1, // Motor 1
    output logic motor_out_2, // Motor 2
    output logic motor_out_3, // Motor 3
    output logic pair_sel_0_n, // Two-drive select 0, active low
    output logic pair_sel_1_n, // Two-drive select 1, active low
    output logic pair_motor_0_n, // Two-drive motor 0, active low
    output logic pair_motor_1_n, // Two-drive motor 1, active low
    output logic soft_reset_n // Core reset, active low
);

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    function automatic fsor_pkg::fsor_mode_t mode_of(input logic ident, input logic encoding_mode_bit);
        fsor_pkg::fsor_mode_t m;
        m = fsor_pkg::fsor_basic;
        unique case ({ident, encoding_mode_bit})
            2'b11: m = fsor_pkg::fsor_basic;
            2'b01: m = fsor_pkg::fsor_enhanced;
            2'b00: m = fsor_pkg::fsor_compact;
            2'b10: m = fsor_pkg::fsor_basic;
        endcase
        return m;
    endfunction

    logic [7:0] drive_motor_output;
    logic [7:0] cfg;
    fsor_pkg::fsor_mode_t mode;
    logic is_enh;
    logic is_cmp;

    assign mode = mode_of(cfg[`FSOR_CFG_IDENT_BIT], cfg[`FSOR_CFG_MFM_BIT]);
    assign is_enh = (mode == fsor_pkg::fsor_enhanced);
    assign is_cmp = (mode == fsor_pkg::fsor_compact);

    // ------------------------------------------------------------
    // AHB-Lite address phase capture
    // ------------------------------------------------------------
    logic a_valid;
    logic a_write;
    logic [3:0] a_idx;
    logic a_ok;
    logic take;

    assign take = hsel && htrans[1] && hready;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_valid <= 1'b0;
            a_write <= 1'b0;
            a_idx <= 4'h0;
            a_ok <= 1'b0;
        end else begin
            a_valid <= take;
            a_write <= take && hwrite;
            a_idx <= haddr[5:2];
            a_ok <= (haddr[31:6] == 26'h000_0000) && (haddr[1:0] == 2'b00);
        end
    end

    logic wr_dor;
    logic wr_cfg;
    assign wr_dor = a_valid && a_write && a_ok && (a_idx == `FSOR_IDX_DOR);
    assign wr_cfg = a_valid && a_write && a_ok && (a_idx == `FSOR_IDX_CFG);

    // ------------------------------------------------------------
    // Output and config registers
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drive_motor_output <= `FSOR_DOR_RESET;
        end else if (wr_dor) begin
            drive_motor_output <= hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg <= `FSOR_CFG_RESET;
        end else if (wr_cfg) begin
            cfg <= {4'h0, hwdata[3:0]};
        end
    end

    // ------------------------------------------------------------
    // Software reset stretch
    // ------------------------------------------------------------
    logic [7:0] srst_cnt;
    logic srst_act;

    assign srst_act = !drive_motor_output[`FSOR_DOR_RST_BIT] || (srst_cnt != 8'h00);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            srst_cnt <= 8'h00;
        end else if (!drive_motor_output[`FSOR_DOR_RST_BIT]) begin
            srst_cnt <= 8'(SRST_CYC - 1);
        end else if (srst_cnt != 8'h00) begin
            srst_cnt <= srst_cnt - 8'h01;
        end
    end

    assign soft_reset_n = !srst_act;

    // ------------------------------------------------------------
    // Drive select and motor outputs
    // ------------------------------------------------------------
    logic [3:0] sel_hot;
    logic [3:0] mot;

    assign mot = drive_motor_output[`FSOR_DOR_MOT_LSB +: 4];

    generate
        for (genvar i = 0; i < 4; i++) begin : g_sel
            assign sel_hot[i] = (drive_motor_output[`FSOR_DOR_SEL_LSB +: 2] == 2'(i));
        end
    endgenerate

    assign drive_sel_out_0 = sel_hot[0];
    assign drive_sel_out_1 = sel_hot[1];
    assign drive_sel_out_2 = sel_hot[2];
    assign drive_sel_out_3 = sel_hot[3];
    assign motor_out_0 = mot[0];
    assign motor_out_1 = mot[1];
    assign motor_out_2 = mot[2];
    assign motor_out_3 = mot[3];
    assign pair_sel_0_n = !(sel_hot[0] && mot[0]);
    assign pair_sel_1_n = !(sel_hot[1] && mot[1]);
    assign pair_motor_0_n = !mot[0];
    assign pair_motor_1_n = !mot[1];

    // ------------------------------------------------------------
    // DMA and interrupt pin gating
    // ------------------------------------------------------------
    logic pins_en;

    assign pins_en = is_enh || drive_motor_output[`FSOR_DOR_DMA_BIT];
    assign floppy_irq_out = core_irq;
    assign dma_req_out = core_drq;
    assign floppy_irq_oe_n = !pins_en;
    assign dma_req_oe_n = !pins_en;
    assign dack_core_n = pins_en ? dack_in_n : 1'b1;
    assign tc_core = pins_en ? tc_in : 1'b0;

    // ------------------------------------------------------------
    // Edge detection and latched status
    // ------------------------------------------------------------
    logic step_q;
    logic wg_q;
    logic rd_q;
    logic wd_q;
    logic step_rise;
    logic wg_rise;
    logic rd_fall;
    logic wd_fall;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            step_q <= 1'b0;
            wg_q <= 1'b0;
            rd_q <= 1'b0;
            wd_q <= 1'b0;
        end else begin
            step_q <= step_out;
            wg_q <= write_gate;
            rd_q <= read_data;
            wd_q <= write_data;
        end
    end

    assign step_rise = step_out && !step_q;
    assign wg_rise = write_gate && !wg_q;
    assign rd_fall = !read_data && rd_q;
    assign wd_fall = !write_data && wd_q;

    logic step_lat;
    logic wg_lat;
    logic rd_lat;
    logic wd_lat;
    logic rd_tog;
    logic wd_tog;

    // Set wins over a clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            step_lat <= 1'b0;
        end else if (step_rise) begin
            step_lat <= 1'b1;
        end else if (dir_read_pulse || srst_act) begin
            step_lat <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wg_lat <= 1'b0;
        end else if (wg_rise) begin
            wg_lat <= 1'b1;
        end else if (dir_read_pulse) begin
            wg_lat <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_lat <= 1'b0;
            wd_lat <= 1'b0;
        end else begin
            if (rd_fall) begin
                rd_lat <= 1'b1;
            end else if (dir_read_pulse) begin
                rd_lat <= 1'b0;
            end
            if (wd_fall) begin
                wd_lat <= 1'b1;
            end else if (dir_read_pulse) begin
                wd_lat <= 1'b0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_tog <= 1'b0;
            wd_tog <= 1'b0;
        end else begin
            if (rd_fall) begin
                rd_tog <= !rd_tog;
            end
            if (wd_fall) begin
                wd_tog <= !wd_tog;
            end
        end
    end

    // ------------------------------------------------------------
    // Status register assembly
    // ------------------------------------------------------------
    logic wp_eff;
    logic [7:0] disk_status_a_compact;
    logic [7:0] disk_status_b_enhanced;

    assign wp_eff = cfg[`FSOR_CFG_FWP_EN_BIT] ? cfg[`FSOR_CFG_FWP_VAL_BIT] : write_protect;

    always_comb begin
        if (is_cmp) begin
            disk_status_a_compact = {core_irq,
                   core_drq,
                   step_lat,
                   track_zero, !head_side, index_in,
                   wp_eff,
                   !head_dir_in};
            disk_status_b_enhanced = {1'b1,
                   !sel_hot[1], !sel_hot[0],
                   wd_lat, rd_lat,
                   wg_lat,
                   !sel_hot[3], !sel_hot[2]};
        end else begin
            disk_status_a_compact = {core_irq,
                   1'b1,
                   step_out,
                   !track_zero, head_side, !index_in, !wp_eff, head_dir_in};
            disk_status_b_enhanced = {2'b11,
                   drive_motor_output[`FSOR_DOR_SEL_LSB],
                   wd_tog, rd_tog,
                   write_gate, mot[1], mot[0]};
        end
    end

    // ------------------------------------------------------------
    // Read data, registered at the address phase
    // ------------------------------------------------------------
    logic [7:0] next_rd;
    logic next_float;
    logic stat_idx;

    always_comb begin
        stat_idx = (haddr[5:2] == `FSOR_IDX_SRA) || (haddr[5:2] == `FSOR_IDX_SRB);
        next_rd = 8'h00;
        if ((haddr[31:6] == 26'h000_0000) && (haddr[1:0] == 2'b00)) begin
            unique case (haddr[5:2])
                `FSOR_IDX_SRA: next_rd = disk_status_a_compact;
                `FSOR_IDX_SRB: next_rd = disk_status_b_enhanced;
                `FSOR_IDX_DOR: next_rd = drive_motor_output;
                `FSOR_IDX_CFG: next_rd = cfg;
                default: next_rd = 8'h00;
            endcase
        end
        next_float = stat_idx && (haddr[31:6] == 26'h000_0000) && (haddr[1:0] == 2'b00) &&
                     (mode == fsor_pkg::fsor_basic);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
            data_float <= 1'b0;
        end else if (take && !hwrite) begin
            hrdata <= next_float ? 32'h0000_0000 : {24'h00_0000, next_rd};
            data_float <= next_float;
        end else begin
            data_float <= 1'b0;
        end
    end

endmodule

/* fsor_checker.sv */
// Port-level checks for the floppy status/output register block.
// Assumes a bind onto fsor_top; one clock hclk, reset hresetn.
`timescale 1ns/100ps
module fsor_checker (
    input wire logic hclk, // Clock
    input wire logic hresetn, // Reset
    input wire logic [31:0] hrdata, // In
    input wire logic data_float, // In
    input wire logic core_irq, // In
    input wire logic core_drq, // In
    input wire logic dma_req_out, // In
    input wire logic floppy_irq_out, // In
    input wire logic floppy_irq_oe_n, // In
    input wire logic dma_req_oe_n, // In
    input wire logic dack_core_n, // In
    input wire logic tc_core, // In
    input wire logic drive_sel_out_0, // In
    input wire logic drive_sel_out_1, // In
    input wire logic drive_sel_out_2, // In
    input wire logic drive_sel_out_3, // In
    input wire logic motor_out_0, // In
    input wire logic motor_out_1, // In
    input wire logic pair_sel_0_n, // In
    input wire logic pair_sel_1_n, // In
    input wire logic pair_motor_0_n, // In
    input wire logic pair_motor_1_n, // In
    input wire logic soft_reset_n // In
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // ------
    // Checks
    // ------
    sel_onehot_a: assert property ($onehot({drive_sel_out_3, drive_sel_out_2, drive_sel_out_1, drive_sel_out_0}))
        else $error("drive selects not one-hot");
    pair_motor_a: assert property (pair_motor_0_n == !motor_out_0 && pair_motor_1_n == !motor_out_1)
        else $error("pair motors not inverse");
    pair_sel_a: assert property (pair_sel_0_n == !(drive_sel_out_0 && motor_out_0)
        && pair_sel_1_n == !(drive_sel_out_1 && motor_out_1)) else $error("pair select wrong");
    pins_gated_a: assert property (dma_req_oe_n |-> dack_core_n && !tc_core)
        else $error("pins not gated");
    oe_match_a: assert property (floppy_irq_oe_n == dma_req_oe_n)
        else $error("pin enables differ");
    srst_min_a: assert property ($fell(soft_reset_n) |=> !soft_reset_n)
        else $error("soft reset too short");
    float_zero_a: assert property (data_float |-> hrdata == 32'h0000_0000)
        else $error("data while floating");
    irq_pin_a: assert property (floppy_irq_out == core_irq)
        else $error("irq pin differs");
    drq_pin_a: assert property (dma_req_out == core_drq)
        else $error("drq pin differs");
    float_c: cover property (data_float);
    srst_c: cover property ($fell(soft_reset_n));
    pair_c: cover property (!pair_sel_0_n);
endmodule

/* fsor_drive_model.sv */
// Floppy drive model: head position, index and read data pulses.
// Assumes step and direction from the block side, sampled on hclk.
`timescale 1ns/100ps
module fsor_drive_model #(
    parameter int START_TRACK = 3
) (
    input wire logic hclk, // Clock
    input wire logic hresetn, // Reset
    input wire logic spin, // Selected with motor on
    input wire logic step_out, // Step
    input wire logic head_dir_in, // 1 inward
    output logic track_zero, // Head on track 0
    output logic index_in, // Index pulse
    output logic read_data // Read pulses
);
    logic [7:0] pos;
    logic [5:0] rot;
    logic step_q;
    // ------
    // Head and disk
    // ------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pos <= 8'(START_TRACK);
            step_q <= 1'h0;
            rot <= 6'h00;
        end else begin
            step_q <= step_out;
            rot <= spin ? rot + 6'h01 : rot;
            if (step_out && !step_q && (head_dir_in || pos != 8'h00)) begin
                pos <= head_dir_in ? pos + 8'h01 : pos - 8'h01;
            end
        end
    end
    assign track_zero = pos == 8'h00;
    assign index_in = spin && rot == 6'h00;
    assign read_data = spin && rot[2];
endmodule

/* floppy_status_output_regs_test.sv */
// Self-checking bench for the floppy status/output register block.
// Assumes fsor_top, fsor_drive_model and fsor_checker compiled first.
`timescale 1ns/100ps
module floppy_status_output_regs_test;
    localparam logic [31:0] a_sra = 32'h0000_0000;
    localparam logic [31:0] a_srb = 32'h0000_0004;
    localparam logic [31:0] a_dor = 32'h0000_0008;
    localparam logic [31:0] a_cfg = 32'h0000_000C;
    logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, hready, hreadyout, hresp, data_float;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic dir_read_pulse = 1'h0, step_out = 1'h0, head_dir_in = 1'h0, write_protect = 1'h0, head_side = 1'h0;
    logic write_gate = 1'h0, write_data = 1'h0, core_irq = 1'h0, core_drq = 1'h0, dack_in_n = 1'h1, tc_in = 1'h0;
    logic track_zero, index_in, read_data, spin, dack_core_n, tc_core, floppy_irq_out, floppy_irq_oe_n;
    logic dma_req_out, dma_req_oe_n, drive_sel_out_0, drive_sel_out_1, drive_sel_out_2, drive_sel_out_3;
    logic motor_out_0, motor_out_1, motor_out_2, motor_out_3, pair_sel_0_n, pair_sel_1_n, pair_motor_0_n;
    logic pair_motor_1_n, soft_reset_n, basic = 1'h1, rd_q = 1'h0, wd_q = 1'h0, rd_par = 1'h0, wd_par = 1'h0;
    logic [7:0] outs, pairs, pins;
    int err_total = 0, comparisons = 0, srst_low = 0;
    assign hready = hreadyout;
    assign spin = motor_out_0 & drive_sel_out_0;
    assign outs = {motor_out_3, motor_out_2, motor_out_1, motor_out_0,
        drive_sel_out_3, drive_sel_out_2, drive_sel_out_1, drive_sel_out_0};
    assign pairs = {4'h0, pair_sel_1_n, pair_sel_0_n, pair_motor_1_n, pair_motor_0_n};
    assign pins = {4'h0, floppy_irq_oe_n, dma_req_oe_n, dack_core_n, tc_core};
    always #25 hclk = ~hclk;
    fsor_top i_dut (.*);
    fsor_drive_model i_drv (.*);
    // ------
    // Edge parity and soft reset length
    // ------
    always @(posedge hclk) begin
        rd_q <= read_data;
        wd_q <= write_data;
        if (rd_q && !read_data) rd_par <= ~rd_par;
        if (wd_q && !write_data) wd_par <= ~wd_par;
        if (hresetn && !soft_reset_n) srst_low <= srst_low + 1;
    end
    // ------
    // Bus and compare tasks
    // ------
    task ck(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task bus(input logic wr, input logic [31:0] a, input logic [7:0] d);
        @(posedge hclk);
        hsel <= 1'h1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hready !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= 32'(d);
        do @(posedge hclk); while (hready !== 1'h1);
    endtask
    task rd(input logic [31:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
        logic f;
        f = basic && a < a_dor;
        bus(1'h0, a, 8'h00);
        ck({7'h00, data_float}, {7'h00, f});
        ck(hrdata[7:0] & (f ? 8'hFF : m), f ? 8'h00 : e & m);
        ck({7'h00, hresp || (hrdata[31:8] != 24'h00_0000)}, 8'h00);
    endtask
    task stop_test();
        $display("mismatches %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ------
    // Scenarios
    // ------
    task t_reset();
        ck(outs, 8'h01);
        ck({5'h00, soft_reset_n, floppy_irq_oe_n, dma_req_oe_n}, 8'h03);
        rd(a_dor, 8'h00);
        rd(a_sra, 8'h00);
        rd(a_srb, 8'h00);
        bus(1'h1, 32'h0000_0010, 8'hFF);
        rd(32'h0000_0010, 8'h00);
        $display("reset test done");
    endtask
    task t_dor();
        logic [7:0] v;
        for (int i = 0; i < 4; i++) begin
            v = (8'h10 << i) | 8'h0C | 8'(i);
            bus(1'h1, a_dor, v);
            rd(a_dor, v);
            @(negedge hclk);
            ck(outs, {4'h1 << i, 4'h1 << i});
            ck(pairs, {4'h0, i != 1, i != 0, i != 1, i != 0});
        end
        bus(1'h1, a_dor, 8'hF6);
        @(negedge hclk);
        ck(outs, 8'hF4);
        ck(pairs, 8'h0C);
        $display("output register test done");
    endtask
    task t_srst();
        bus(1'h1, a_dor, 8'h1C);
        repeat (4) @(posedge hclk);
        srst_low = 0;
        bus(1'h1, a_dor, 8'h18);
        bus(1'h1, a_dor, 8'h1C);
        repeat (4) @(posedge hclk);
        ck({6'h00, srst_low >= 2, soft_reset_n}, 8'h03);
        rd(a_dor, 8'h1C);
        ck(outs, 8'h11);
        $display("soft reset test done");
    endtask
    task t_enh();
        bus(1'h1, a_cfg, 8'h01);
        basic = 1'h0;
        bus(1'h1, a_dor, 8'h35);
        step_out <= 1'h1;
        core_irq <= 1'h1;
        write_gate <= 1'h1;
        rd(a_sra, 8'hE0, 8'hE0);
        step_out <= 1'h0;
        core_irq <= 1'h0;
        rd(a_sra, 8'h40, 8'hE0);
        rd(a_srb, {3'h7, wd_par, rd_par, 3'h7});
        write_data <= 1'h1;
        @(posedge hclk);
        write_data <= 1'h0;
        repeat (2) @(posedge hclk);
        rd(a_srb, {3'h7, wd_par, rd_par, 3'h7});
        bus(1'h1, a_dor, 8'h31);
        @(negedge hclk);
        ck(pins, 8'h02);
        bus(1'h1, a_dor, 8'h26);
        rd(a_srb, {3'h6, wd_par, rd_par, 3'h6});
        $display("enhanced mode test done");
    endtask
    task t_cmp();
        bus(1'h1, a_cfg, 8'h00);
        bus(1'h1, a_dor, 8'h0E);
        write_gate <= 1'h0;
        head_side <= 1'h1;
        write_protect <= 1'h1;
        core_irq <= 1'h1;
        core_drq <= 1'h1;
        repeat (4) begin
            @(posedge hclk);
            step_out <= 1'h1;
            @(posedge hclk);
            step_out <= 1'h0;
        end
        rd(a_sra, 8'hF3);
        head_dir_in <= 1'h1;
        head_side <= 1'h0;
        write_protect <= 1'h0;
        core_irq <= 1'h0;
        core_drq <= 1'h0;
        dir_read_pulse <= 1'h1;
        @(posedge hclk);
        dir_read_pulse <= 1'h0;
        rd(a_sra, 8'h18);
        bus(1'h1, a_cfg, 8'h0C);
        rd(a_sra, 8'h02, 8'h02);
        bus(1'h1, a_cfg, 8'h00);
        rd(a_srb, 8'hE2);
        write_data <= 1'h1;
        @(posedge hclk);
        write_data <= 1'h0;
        @(posedge hclk);
        write_gate <= 1'h1;
        rd(a_srb, 8'hF6);
        dir_read_pulse <= 1'h1;
        @(posedge hclk);
        dir_read_pulse <= 1'h0;
        rd(a_srb, 8'hE2);
        bus(1'h1, a_dor, 8'h1C);
        repeat (20) @(posedge hclk);
        rd(a_srb, 8'hCB, 8'hEB);
        dack_in_n <= 1'h0;
        tc_in <= 1'h1;
        @(negedge hclk);
        ck(pins, 8'h01);
        bus(1'h1, a_dor, 8'h14);
        @(negedge hclk);
        ck(pins, 8'h0E);
        $display("compact mode test done");
    endtask
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'h1;
        t_reset();
        t_dor();
        t_srst();
        t_enh();
        t_cmp();
        stop_test();
    end
    initial begin
        #(50 * 20000);
        err_total++;
        $display("[FAIL] %0t watchdog expired", $time);
        stop_test();
    end
endmodule
bind fsor_top fsor_checker i_chk (.*);
